// >>> tcc_pkg.sv
// Constants and types of the capture/compare timer control block
package tcc_pkg;
   // ==========================================
   // Register byte addresses
   localparam logic [7:0] A_CR1 = 8'h00;
   localparam logic [7:0] A_CR2 = 8'h04;
   localparam logic [7:0] A_CSR = 8'h08;
   localparam logic [7:0] A_IC1H = 8'h0C;
   localparam logic [7:0] A_IC1L = 8'h10;
   localparam logic [7:0] A_OC1H = 8'h14;
   localparam logic [7:0] A_OC1L = 8'h18;
   localparam logic [7:0] A_CNTH = 8'h1C;
   localparam logic [7:0] A_CNTL = 8'h20;
   localparam logic [7:0] A_ACNTH = 8'h24;
   localparam logic [7:0] A_ACNTL = 8'h28;
   localparam logic [7:0] A_IC2H = 8'h2C;
   localparam logic [7:0] A_IC2L = 8'h30;
   localparam logic [7:0] A_OC2H = 8'h34;
   localparam logic [7:0] A_OC2L = 8'h38;
   // ==========================================
   // Field positions, resets, clock codes
   localparam int OFF_BIT = 2;
   localparam int FLAG_LSB = 3;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'hFFFC;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CMP_RST = 16'hFFFF;
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [2:0] PRE_DIV2 = 3'h1;
   localparam logic [2:0] PRE_DIV4 = 3'h3;
   localparam logic [2:0] PRE_DIV8 = 3'h7;
   // ==========================================
   // Control register layouts
   typedef struct packed {
      logic capture_irq_en;
      logic match_irq_en;
      logic overflow_irq_en;
      logic force2;
      logic force1;
      logic compare2_level;
      logic cap1_edge_sel;
      logic compare1_level;
   } tcc_cr1_t;
   typedef struct packed {
      logic cmp1_pin_en;
      logic cmp2_pin_en;
      logic single_pulse_sel;
      logic pwm_sel;
      logic [1:0] timer_clk_sel;
      logic cap2_edge_sel;
      logic ext_clk_edge_sel;
   } tcc_cr2_t;
   // Flag order matches status bits 7..3
   typedef struct packed {
      logic cap1_flag;
      logic match1_flag;
      logic overflow_flag;
      logic cap2_flag;
      logic match2_flag;
   } tcc_flags_t;
endpackage

// >>> tcc_timer.sv
// Capture/compare timer control block with AHB-Lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tcc_timer #(
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic capture1_in_pin,
   input wire logic capture2_in_pin,
   input wire logic ext_timer_clk_pin,
   output logic compare1_out_pin,
   output logic compare1_out_en,
   output logic compare2_out_pin,
   output logic compare2_out_en,
   output logic timer_irq
);
   // ==========================================
   // Helpers
   function automatic logic edge_of(input logic rise, input logic now, input logic old);
      edge_of = rise ? (now & ~old) : (~now & old);
   endfunction

   function automatic logic pre_tick(input logic [1:0] sel, input logic [2:0] p);
      unique case (sel)
         tcc_pkg::CLK_DIV2: pre_tick = (p & tcc_pkg::PRE_DIV2) == tcc_pkg::PRE_DIV2;
         tcc_pkg::CLK_DIV4: pre_tick = (p & tcc_pkg::PRE_DIV4) == tcc_pkg::PRE_DIV4;
         tcc_pkg::CLK_DIV8: pre_tick = p == tcc_pkg::PRE_DIV8;
         default: pre_tick = 1'b0;
      endcase
   endfunction

   // ==========================================
   // State
   tcc_pkg::tcc_cr1_t cr1;
   tcc_pkg::tcc_cr2_t cr2;
   tcc_pkg::tcc_flags_t flags;
   tcc_pkg::tcc_flags_t armed;
   logic timer_off;
   logic [2:0] presc;
   logic [15:0] cnt;
   logic [15:0] compare1_value;
   logic [15:0] compare2_value;
   logic [15:0] cap1_val;
   logic [15:0] cap2_val;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic pend;
   logic pend_wr;
   logic [7:0] pend_addr;

   // ==========================================
   // Pin synchronisers: first stage feeds second only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
      end else begin
         sync1 <= {ext_timer_clk_pin, capture2_in_pin, capture1_in_pin};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire cap1_ev = edge_of(cr1.cap1_edge_sel, sync2[0], sync3[0]);
   wire cap2_ev = edge_of(cr2.cap2_edge_sel, sync2[1], sync3[1]);
   wire ext_ev = edge_of(cr2.ext_clk_edge_sel, sync2[2], sync3[2]);

   // ==========================================
   // Bus decode
   wire take = hsel & hready & htrans[1];
   wire bus_rd = pend & ~pend_wr;
   wire bus_wr = pend & pend_wr;
   wire hit_cr1 = pend_addr == tcc_pkg::A_CR1;
   wire hit_cr2 = pend_addr == tcc_pkg::A_CR2;
   wire hit_csr = pend_addr == tcc_pkg::A_CSR;
   wire hit_ic1l = pend_addr == tcc_pkg::A_IC1L;
   wire hit_oc1h = pend_addr == tcc_pkg::A_OC1H;
   wire hit_oc1l = pend_addr == tcc_pkg::A_OC1L;
   wire hit_cntl = pend_addr == tcc_pkg::A_CNTL;
   wire hit_ic2l = pend_addr == tcc_pkg::A_IC2L;
   wire hit_oc2h = pend_addr == tcc_pkg::A_OC2H;
   wire hit_oc2l = pend_addr == tcc_pkg::A_OC2L;
   wire [7:0] wbyte = hwdata[7:0];
   wire wr_cr1 = bus_wr & hit_cr1;
   wire wr_cnt = bus_wr & hit_cntl;
   // Written byte seen through the layout of the first control register
   tcc_pkg::tcc_cr1_t cr1_wr;
   assign cr1_wr = wbyte;

   // ==========================================
   // Counter timing
   wire mode_pwm = cr2.pwm_sel;
   wire mode_opm = cr2.single_pulse_sel & ~mode_pwm;
   // Missing external pin: the ext code yields no ticks at all
   wire ext_tick = HAS_EXT_CLK & ext_ev;
   wire sel_ext = cr2.timer_clk_sel == tcc_pkg::CLK_EXT;
   wire raw_tick = sel_ext ? ext_tick : pre_tick(cr2.timer_clk_sel, presc);
   wire tick = raw_tick & ~timer_off;
   wire [15:0] cnt_inc = cnt + 16'h0001;
   wire period_end = tick & mode_pwm & (cnt == compare2_value);
   wire opm_start = mode_opm & cap1_ev & ~timer_off;
   wire wrap = tick & ~period_end & (cnt == tcc_pkg::CNT_MAX);
   wire match1 = tick & ~period_end & (cnt_inc == compare1_value);
   wire match2 = tick & ~period_end & (cnt_inc == compare2_value);

   // ==========================================
   // Flag set and two-step clear terms
   tcc_pkg::tcc_flags_t set_f;
   tcc_pkg::tcc_flags_t clr_f;
   assign set_f.cap1_flag = cap1_ev | period_end;
   assign set_f.match1_flag = match1 & ~mode_pwm;
   assign set_f.overflow_flag = wrap;
   assign set_f.cap2_flag = cap2_ev;
   assign set_f.match2_flag = match2 & ~mode_pwm;
   assign clr_f.cap1_flag = pend & hit_ic1l & armed.cap1_flag;
   assign clr_f.match1_flag = pend & hit_oc1l & armed.match1_flag;
   // Alternate counter address is deliberately absent here
   assign clr_f.overflow_flag = pend & hit_cntl & armed.overflow_flag;
   assign clr_f.cap2_flag = pend & hit_ic2l & armed.cap2_flag;
   assign clr_f.match2_flag = pend & hit_oc2l & armed.match2_flag;
   wire csr_rd = bus_rd & hit_csr;

   // ==========================================
   // Read mux
   logic [7:0] rd_byte;
   always_comb begin
      unique case (pend_addr)
         tcc_pkg::A_CR1: rd_byte = cr1;
         tcc_pkg::A_CR2: rd_byte = cr2;
         tcc_pkg::A_CSR: rd_byte = {flags, timer_off, 2'b00};
         tcc_pkg::A_IC1H: rd_byte = cap1_val[15:8];
         tcc_pkg::A_IC1L: rd_byte = cap1_val[7:0];
         tcc_pkg::A_OC1H: rd_byte = compare1_value[15:8];
         tcc_pkg::A_OC1L: rd_byte = compare1_value[7:0];
         tcc_pkg::A_CNTH: rd_byte = cnt[15:8];
         tcc_pkg::A_CNTL: rd_byte = cnt[7:0];
         tcc_pkg::A_ACNTH: rd_byte = cnt[15:8];
         tcc_pkg::A_ACNTL: rd_byte = cnt[7:0];
         tcc_pkg::A_IC2H: rd_byte = cap2_val[15:8];
         tcc_pkg::A_IC2L: rd_byte = cap2_val[7:0];
         tcc_pkg::A_OC2H: rd_byte = compare2_value[15:8];
         tcc_pkg::A_OC2L: rd_byte = compare2_value[7:0];
         default: rd_byte = 8'h00;
      endcase
   end

   // ==========================================
   // AHB-Lite slave: one wait state, access done at data-phase first edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 1'b0;
         pend_wr <= 1'b0;
         pend_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         if (pend) begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= {24'h00_0000, pend_wr ? 8'h00 : rd_byte};
         end else if (take) begin
            pend <= 1'b1;
            pend_wr <= hwrite;
            pend_addr <= {haddr[7:2], 2'b00};
            hreadyout <= 1'b0;
         end
      end
   end

   // ==========================================
   // Control registers, writable in any timer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cr1 <= tcc_pkg::CTRL_RST;
         cr2 <= tcc_pkg::CTRL_RST;
         timer_off <= 1'b0;
         compare1_value <= tcc_pkg::CMP_RST;
         compare2_value <= tcc_pkg::CMP_RST;
      end else if (bus_wr) begin
         if (hit_cr1)
            cr1 <= wbyte;
         if (hit_cr2)
            cr2 <= wbyte;
         // Low two status bits are ignored on write
         if (hit_csr)
            timer_off <= wbyte[tcc_pkg::OFF_BIT];
         if (hit_oc1h)
            compare1_value[15:8] <= wbyte;
         if (hit_oc1l)
            compare1_value[7:0] <= wbyte;
         if (hit_oc2h)
            compare2_value[15:8] <= wbyte;
         if (hit_oc2l)
            compare2_value[7:0] <= wbyte;
      end
   end

   // ==========================================
   // Flags: set beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
         armed <= '0;
      end else begin
         flags <= (flags & ~clr_f) | set_f;
         if (csr_rd)
            armed <= flags;
         else
            armed <= armed & ~clr_f;
      end
   end

   // ==========================================
   // Prescaler and counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc <= 3'h0;
         cnt <= tcc_pkg::CNT_RST;
      end else begin
         if (!timer_off)
            presc <= presc + 3'h1;
         if (wr_cnt || opm_start || period_end)
            cnt <= tcc_pkg::CNT_RST;
         else if (tick)
            cnt <= cnt_inc;
      end
   end

   // Capture holders are not reset; contents undefined until first event
   always_ff @(posedge hclk) begin
      if (cap1_ev)
         cap1_val <= cnt;
      if (cap2_ev)
         cap2_val <= cnt;
   end

   // ==========================================
   // Compare output levels and pin enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare1_out_pin <= 1'b0;
         compare2_out_pin <= 1'b0;
         compare1_out_en <= 1'b0;
         compare2_out_en <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         compare1_out_en <= cr2.cmp1_pin_en & ~timer_off;
         compare2_out_en <= cr2.cmp2_pin_en & ~timer_off;
         if (mode_pwm || mode_opm) begin
            // Pulse starts at level 2, ends at level 1
            if (period_end || opm_start)
               compare1_out_pin <= cr1.compare2_level;
            else if (match1)
               compare1_out_pin <= cr1.compare1_level;
         end else if (match1 || (wr_cr1 && cr1_wr.force1)) begin
            compare1_out_pin <= wr_cr1 ? cr1_wr.compare1_level : cr1.compare1_level;
         end
         if (!mode_pwm && (match2 || (wr_cr1 && cr1_wr.force2)))
            compare2_out_pin <= wr_cr1 ? cr1_wr.compare2_level : cr1.compare2_level;
         timer_irq <= (cr1.capture_irq_en & (flags.cap1_flag | flags.cap2_flag))
            | (cr1.match_irq_en & (flags.match1_flag | flags.match2_flag))
            | (cr1.overflow_irq_en & flags.overflow_flag);
      end
   end

   wire unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0], hwdata[31:8]};

endmodule

// >>> tcc_timer_bench.sv
// Self-checking bench of the capture/compare timer control block
`timescale 1ns/1ps
module tcc_timer_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic cap1 = 1'b0;
   logic cap2 = 1'b0;
   logic extc = 1'b0;
   wire logic hreadyout, hresp, pin1, en1, pin2, en2, irq;
   wire logic [31:0] hrdata;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] d;
   tcc_timer i_tcc_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .capture1_in_pin(cap1),
      .capture2_in_pin(cap2), .ext_timer_clk_pin(extc), .compare1_out_pin(pin1),
      .compare1_out_en(en1), .compare2_out_pin(pin2), .compare2_out_en(en2), .timer_irq(irq));
   initial forever #2 hclk = ~hclk;
   // Hang guard, run needs about a thousand cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end
   // ==========================================
   // Bus and compare tasks
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prescaler phase is unknown, so one tick of slack
   task automatic cmp_near(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp && got !== exp + 8'h01) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      xfer(a, 1'b0, 8'h00);
      cmp8(d[7:0] & m, exp);
   endtask
   task automatic edge_chk(input logic v, input logic [7:0] exp);
      extc <= v;
      repeat (8) @(posedge hclk);
      chk_rd(tcc_pkg::A_CNTL, 8'hFF, exp);
   endtask
   // Cycles until pin1 shows v, capped so a dead pin cannot hang here
   task automatic wait_pin1(input logic v, output int n);
      n = 0;
      while (pin1 !== v && n < 500) begin
         @(posedge hclk);
         n++;
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk_rd(tcc_pkg::A_CSR, 8'hF8, 8'h00);
      chk_rd(tcc_pkg::A_CR2, 8'hFF, 8'h00);
      chk_rd(8'h3C, 8'hFF, 8'h00);
   endtask
   task automatic t_ovf();
      repeat (40) @(posedge hclk);
      chk_rd(tcc_pkg::A_CSR, 8'h28, 8'h28);
      xfer(tcc_pkg::A_ACNTL, 1'b0, 8'h00);
      chk_rd(tcc_pkg::A_CSR, 8'h20, 8'h20);
      xfer(tcc_pkg::A_CNTL, 1'b0, 8'h00);
      xfer(tcc_pkg::A_OC2L, 1'b0, 8'h00);
      chk_rd(tcc_pkg::A_CSR, 8'h28, 8'h00);
   endtask
   task automatic t_off();
      logic [7:0] c;
      xfer(tcc_pkg::A_CR2, 1'b1, 8'hC0);
      repeat (3) @(posedge hclk);
      cmp8({6'h0, en1, en2}, 8'h03);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h04);
      repeat (3) @(posedge hclk);
      cmp8({6'h0, en1, en2}, 8'h00);
      xfer(tcc_pkg::A_CNTL, 1'b0, 8'h00);
      c = d[7:0];
      repeat (20) @(posedge hclk);
      chk_rd(tcc_pkg::A_CNTL, 8'hFF, c);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h84);
      chk_rd(tcc_pkg::A_CR2, 8'hFF, 8'h84);
   endtask
   // Counter runs for 63 cycles between the two timer-off writes
   task automatic t_rate(input logic [1:0] sel, input int div);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h04);
      xfer(tcc_pkg::A_CNTL, 1'b1, 8'h00);
      xfer(tcc_pkg::A_CR2, 1'b1, {4'h0, sel, 2'h0});
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h00);
      repeat (60) @(posedge hclk);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h04);
      xfer(tcc_pkg::A_CNTL, 1'b0, 8'h00);
      cmp_near(d[7:0], 8'hFC + 8'(63 / div));
   endtask
   task automatic t_ext();
      xfer(tcc_pkg::A_CNTL, 1'b1, 8'h00);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h0D);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h00);
      edge_chk(1'b1, 8'hFD);
      edge_chk(1'b0, 8'hFD);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h0C);
      edge_chk(1'b1, 8'hFD);
      edge_chk(1'b0, 8'hFE);
   endtask
   task automatic t_cap2();
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h00);
      cap2 <= 1'b1;
      repeat (8) @(posedge hclk);
      chk_rd(tcc_pkg::A_CSR, 8'h10, 8'h00);
      cap2 <= 1'b0;
      repeat (8) @(posedge hclk);
      chk_rd(tcc_pkg::A_CSR, 8'h10, 8'h10);
      xfer(tcc_pkg::A_IC2L, 1'b0, 8'h00);
      chk_rd(tcc_pkg::A_CSR, 8'h10, 8'h00);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h02);
      cap2 <= 1'b1;
      repeat (8) @(posedge hclk);
      chk_rd(tcc_pkg::A_CSR, 8'h10, 8'h10);
   endtask
   // Timer held off while set up, so stale match flags are cleared first
   task automatic t_match1();
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h04);
      xfer(tcc_pkg::A_CSR, 1'b0, 8'h00);
      xfer(tcc_pkg::A_OC1H, 1'b1, 8'h00);
      xfer(tcc_pkg::A_OC1L, 1'b1, 8'h10);
      xfer(tcc_pkg::A_OC2H, 1'b1, 8'h00);
      xfer(tcc_pkg::A_OC2L, 1'b1, 8'h20);
      xfer(tcc_pkg::A_CNTL, 1'b1, 8'h00);
      xfer(tcc_pkg::A_CR1, 1'b1, 8'h47);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h80);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h00);
      cmp8({7'h0, irq}, 8'h00);
      repeat (150) @(posedge hclk);
      cmp8({6'h0, en1, en2}, 8'h02);
      cmp8({6'h0, pin1, pin2}, 8'h03);
      cmp8({7'h0, irq}, 8'h01);
      chk_rd(tcc_pkg::A_CSR, 8'h48, 8'h48);
      xfer(tcc_pkg::A_OC1L, 1'b0, 8'h00);
      chk_rd(tcc_pkg::A_CSR, 8'h40, 8'h00);
      cap1 <= 1'b1;
      repeat (8) @(posedge hclk);
      chk_rd(tcc_pkg::A_CSR, 8'h80, 8'h80);
      chk_rd(tcc_pkg::A_IC1H, 8'hFF, 8'h00);
      xfer(tcc_pkg::A_IC1L, 1'b0, 8'h00);
      chk_rd(tcc_pkg::A_CSR, 8'h80, 8'h00);
   endtask
   // Pulse 0008 from FFFC is 12 ticks, rest of period to 0010 is 9 ticks
   task automatic t_pwm();
      int n;
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h04);
      xfer(tcc_pkg::A_CSR, 1'b0, 8'h00);
      xfer(tcc_pkg::A_OC2L, 1'b1, 8'h10);
      xfer(tcc_pkg::A_OC1L, 1'b1, 8'h08);
      xfer(tcc_pkg::A_CNTL, 1'b1, 8'h00);
      xfer(tcc_pkg::A_CR1, 1'b1, 8'h04);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h90);
      xfer(tcc_pkg::A_CSR, 1'b1, 8'h00);
      wait_pin1(1'b0, n);
      wait_pin1(1'b1, n);
      cmp8(8'(n), 8'h24);
      wait_pin1(1'b0, n);
      cmp8(8'(n), 8'h30);
      chk_rd(tcc_pkg::A_CSR, 8'hC8, 8'h80);
   endtask
   // Start phase against the prescaler is free, so length is judged in ticks
   task automatic t_opm();
      int n;
      xfer(tcc_pkg::A_CR2, 1'b1, 8'h80);
      xfer(tcc_pkg::A_CR1, 1'b1, 8'h0E);
      xfer(tcc_pkg::A_CR2, 1'b1, 8'hA0);
      cap1 <= 1'b0;
      repeat (8) @(posedge hclk);
      cap1 <= 1'b1;
      wait_pin1(1'b1, n);
      wait_pin1(1'b0, n);
      cmp8(8'((n + 3) / 4), 8'h0C);
      repeat (100) @(posedge hclk);
      cmp8({7'h0, pin1}, 8'h00);
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_ovf();
      t_off();
      t_rate(tcc_pkg::CLK_DIV4, 4);
      t_rate(tcc_pkg::CLK_DIV2, 2);
      t_rate(tcc_pkg::CLK_DIV8, 8);
      t_ext();
      t_cap2();
      t_match1();
      t_pwm();
      t_opm();
      end_sim();
   end
endmodule

// >>> tcc_timer_chk.sv
// Checker of bus timing and timer-off pin behaviour of the timer control block
`timescale 1ns/1ps
module tcc_timer_chk #(
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic compare1_out_en,
   input wire logic compare2_out_en
);
   // ==========================================
   // Address phase decode
   wire logic take = hsel && hready && htrans[1];
   wire logic [5:0] word = haddr[7:2];
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_take_rd(logic [5:0] w);
      take && !hwrite && word == w;
   endsequence
   sequence s_data_phase;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_off_wr;
      take && hwrite && word == tcc_pkg::A_CSR[7:2] ##1 hwdata[tcc_pkg::OFF_BIT];
   endsequence
   // ==========================================
   // Assertions
   chk_wait_state: assert property (take |=> s_data_phase)
      else $error("bus answer not one wait state");
   chk_single_wait: assert property (!hreadyout |=> hreadyout)
      else $error("ready low longer than one cycle");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a transfer");
   chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_status_rsvd: assert property (
      s_take_rd(tcc_pkg::A_CSR[7:2]) ##1 s_data_phase |-> hrdata[1:0] == 2'h0)
      else $error("status low bits not zero");
   chk_unmapped_zero: assert property (s_take_rd(6'h0F) ##1 s_data_phase |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_off_pins: assert property (
      s_off_wr |-> ##[1:3] (!compare1_out_en && !compare2_out_en))
      else $error("compare pins still enabled while timer off");
endmodule

bind tcc_timer tcc_timer_chk #(.HAS_EXT_CLK(HAS_EXT_CLK)) i_tcc_timer_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .compare1_out_en(compare1_out_en),
   .compare2_out_en(compare2_out_en));
